// [target_slew_ramp_engine.sv]
// Purpose: Target/slew RAM autoramp engine, one sweep of all 64 locations
//          per audio frame.
// Assumes: Host target writes arrive as a one-cycle strobe with a full
//          34-bit word; a frame tick arrives no faster than every 65 clocks.
// Notes:   One location is processed per clock while a sweep runs.
`timescale 1ns/100ps
// Function
// R1 - Host pads the 34-bit linear/dB/RC word to five bytes with zeros.
// R2 - Word splits into 2-bit curve, 4-bit time constant, 28-bit 5.23 data.
// R3 - Constant-time word is also five bytes, decoded as five fields.
// R4 - Host sets refresh flag on load; device clears it after recomputing step.
// R5 - Step count code gives 2^(code+6) steps; code 111 yields 8192.
// R6 - Constant-time data is 16-bit signed 2.14.
// R7 - Host writes the 12 reserved constant-time bits as zero.
// R8 - Reset: targets linear, constant 5, data 1.0; slews 1.0.
// R9 - Reset defaults ramp full scale 1.0 to 0.0 in 21.3 ms.
// R10 - Linear step is 2^13 scaled by power of ten from constant minus 5.
// R11 - Linear reaches -60 dB between 6.75 ms and 213.4 ms.
// R12 - Exponential curves use shifts and adds only.
// R13 - Curve 01 takes step size from current slew value.
// R14 - Curve 10 takes step size from target minus slew difference.
// R15 - Constant-time step is (target - slew)/steps, computed once per load.
// R16 - Constant-time ramp finishes in the same number of updates always.
// R17 - Curve codes: 00 linear, 01 dB, 10 RC, 11 constant time.
// R18 - A target write starts the ramp; each location advances once per frame.
// R19 - Global mute forces targets to zero; clearing restores premuted targets.
// R20 - Mute does not affect constant-time locations.
// R21 - Slew clamps at target, never overshoots, stops once equal; constant-time ramps set the target only on their last update.
// R22 - Every location is processed exactly once per frame, idle ones too.
module target_slew_ramp_engine (
  input wire logic i_clk_sys,                    // Core clock, 40 MHz
  input wire logic i_arst_n,                     // Async reset, active low
  input wire logic i_tgt_wr,                     // Target write strobe
  input wire ramp_pkg::tgt_wr_s i_tgt_wr_req,    // Write address and word
  input wire logic i_frame_tick,                 // One pulse per audio frame
  input wire logic i_mute,                       // Global mute level
  input wire logic [ramp_pkg::LOC_AW-1:0] i_rd_addr, // Slew read address
  output logic [ramp_pkg::VAL_W-1:0] o_rd_slew,  // Registered slew read
  output logic o_sweep_busy,                     // Sweep in progress
  output logic o_frame_done                      // Pulse at sweep end
);
  import ramp_pkg::*;

  logic [TGT_W-1:0] target_mem_ff [LOC_NUM];
  logic [VAL_W-1:0] slew_mem_ff [LOC_NUM];
  logic signed [VAL_W:0] ct_step_mem_ff [LOC_NUM];
  logic [CNT_W-1:0] ct_cnt_mem_ff [LOC_NUM];
  logic [LOC_AW-1:0] idx_ff;
  logic busy_ff;
  logic done_ff;
  logic [VAL_W-1:0] rd_slew_ff;

  logic [TGT_W-1:0] tw;
  curve_e curve;
  logic [3:0] tconst;
  logic upd;
  logic [3:0] nsh;
  logic signed [15:0] ct_data;
  logic signed [VAL_W:0] eff_tgt;
  logic signed [VAL_W:0] cur;
  logic signed [VAL_W:0] diff;
  logic [VAL_W:0] dmag;
  logic [VAL_W:0] mag;
  logic [4:0] esh;
  logic [VAL_W-1:0] nxt_slew;
  logic signed [VAL_W:0] nxt_ct_step;
  logic [CNT_W-1:0] nxt_ct_cnt;
  logic nxt_clr_upd;

  function automatic logic [VAL_W:0] abs_val(input logic signed [VAL_W:0] v);
    // Both operands at full width so the sign bit is never dropped
    abs_val = v[VAL_W] ? (VAL_W+1)'(0) - v : v;
  endfunction

  // Decode of the word at the location under sweep
  always_comb begin
    tw = target_mem_ff[idx_ff];
    curve = curve_e'(tw[CURVE_MSB:CURVE_LSB]); // R17
    tconst = tw[TCONST_MSB:TCONST_LSB]; // R2
    upd = tw[UPD_BIT]; // R3
    nsh = {1'b0, tw[NSTEP_MSB:NSTEP_LSB]} + NSTEP_BASE; // R5
    ct_data = tw[CTDATA_MSB:CTDATA_LSB]; // R6
    cur = {slew_mem_ff[idx_ff][VAL_W-1], slew_mem_ff[idx_ff]};
    // Premuted target stays in memory, so unmuting restores it
    if (curve == CURVE_CONST_TIME) begin
      eff_tgt = {{4{ct_data[15]}}, ct_data, 9'h000}; // R6 R20
    end else if (i_mute) begin
      eff_tgt = '0; // R19
    end else begin
      eff_tgt = {tw[VAL_W-1], tw[VAL_W-1:0]}; // R2
    end
  end

  // Step magnitude per curve; exponential curves only shift
  always_comb begin
    diff = eff_tgt - cur;
    dmag = abs_val(diff);
    esh = {1'b0, tconst} + EXP_SHIFT_BASE; // R12
    unique case (curve)
      CURVE_LINEAR: mag = (VAL_W+1)'(LIN_STEP[tconst]); // R10 R9 R11
      CURVE_CONST_DB: mag = abs_val(cur) >> esh; // R13
      CURVE_RC: mag = dmag >> esh; // R14
      CURVE_CONST_TIME: mag = '0;
    endcase
    // A zero step would stall the ramp at a small value forever
    if (mag == '0) begin
      mag = (VAL_W+1)'(1);
    end
  end

  // Next slew value and constant-time bookkeeping
  always_comb begin
    nxt_slew = slew_mem_ff[idx_ff];
    nxt_ct_step = ct_step_mem_ff[idx_ff];
    nxt_ct_cnt = ct_cnt_mem_ff[idx_ff];
    nxt_clr_upd = 1'b0;
    if (curve == CURVE_CONST_TIME) begin
      if (upd) begin
        // Power-of-two count makes the division a plain shift
        nxt_ct_step = diff >>> nsh; // R15
        nxt_ct_cnt = CNT_W'(1) << nsh; // R5
        nxt_clr_upd = 1'b1; // R4
      end else if (nxt_ct_cnt != '0) begin
        nxt_ct_cnt = nxt_ct_cnt - CNT_W'(1);
        // Last update lands exactly on target, hiding step rounding
        if (ct_cnt_mem_ff[idx_ff] == CNT_W'(1)) begin
          nxt_slew = eff_tgt[VAL_W-1:0]; // R16 R21
        end else begin
          nxt_slew = VAL_W'(cur + nxt_ct_step); // R15
        end
      end
    end else if (diff != '0) begin // R21
      if (dmag <= mag) begin
        nxt_slew = eff_tgt[VAL_W-1:0]; // R21
      end else if (diff[VAL_W]) begin
        nxt_slew = VAL_W'(cur - $signed(mag));
      end else begin
        nxt_slew = VAL_W'(cur + $signed(mag));
      end
    end
  end

  // Sweep sequencer: starts on the frame tick, visits 0..63 once
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (busy_ff) begin
        idx_ff <= idx_ff + LOC_AW'(1); // R22
        if (idx_ff == LOC_LAST) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end else if (i_frame_tick) begin
        busy_ff <= 1'b1; // R18 R22
        idx_ff <= '0;
      end
    end
  end

  // Target memory: host write wins over the refresh-flag clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < LOC_NUM; i++) begin
        target_mem_ff[i] <= TGT_RESET; // R8
      end
    end else begin
      if (busy_ff && nxt_clr_upd) begin
        target_mem_ff[idx_ff][UPD_BIT] <= 1'b0; // R4
      end
      if (i_tgt_wr) begin
        target_mem_ff[i_tgt_wr_req.addr] <= i_tgt_wr_req.data; // R18 R1
      end
    end
  end

  // Slew and constant-time state, written only by the sweep
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < LOC_NUM; i++) begin
        slew_mem_ff[i] <= VAL_ONE; // R8
        ct_step_mem_ff[i] <= '0;
        ct_cnt_mem_ff[i] <= '0;
      end
    end else if (busy_ff) begin
      slew_mem_ff[idx_ff] <= nxt_slew; // R18
      ct_step_mem_ff[idx_ff] <= nxt_ct_step;
      ct_cnt_mem_ff[idx_ff] <= nxt_ct_cnt;
    end
  end

  // Registered slew readback
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_slew_ff <= '0;
    end else begin
      rd_slew_ff <= slew_mem_ff[i_rd_addr];
    end
  end

  assign o_rd_slew = rd_slew_ff;
  assign o_sweep_busy = busy_ff;
  assign o_frame_done = done_ff;
endmodule

// [ramp_pkg.sv]
// Purpose: Shared constants and types for the target/slew ramp engine.
// Assumes: 64 ramp locations, 5.23 slew values, one sweep per audio frame.
// Notes:   Field positions follow the 34-bit target word layout.
package ramp_pkg;
  localparam int unsigned LOC_NUM = 64;
  localparam int unsigned LOC_AW = 6;
  localparam int unsigned TGT_W = 34;
  localparam int unsigned VAL_W = 28;
  localparam int unsigned CNT_W = 14;
  localparam logic [LOC_AW-1:0] LOC_LAST = 6'h3f;

  // Target word fields
  localparam int unsigned CURVE_MSB = 33;
  localparam int unsigned CURVE_LSB = 32;
  localparam int unsigned TCONST_MSB = 31;
  localparam int unsigned TCONST_LSB = 28;
  localparam int unsigned UPD_BIT = 31;
  localparam int unsigned NSTEP_MSB = 30;
  localparam int unsigned NSTEP_LSB = 28;
  localparam int unsigned CTDATA_MSB = 27;
  localparam int unsigned CTDATA_LSB = 12;
  localparam int unsigned CT_TO_523_SHIFT = 9;  // 2.14 to 5.23
  localparam logic [3:0] NSTEP_BASE = 4'h6;     // Steps = 2^(code+6)
  localparam logic [4:0] EXP_SHIFT_BASE = 5'h04;

  typedef enum logic [1:0] {
    CURVE_LINEAR = 2'h0,
    CURVE_CONST_DB = 2'h1,
    CURVE_RC = 2'h2,
    CURVE_CONST_TIME = 2'h3
  } curve_e;

  // Reset defaults: linear, time constant 5, data 1.0
  localparam logic [VAL_W-1:0] VAL_ONE = 28'h0800000;
  localparam logic [TGT_W-1:0] TGT_RESET = {2'h0, 4'h5, 28'h0800000};

  // Linear step per time constant: 2^13 / 10^((t-5)/10), in 5.23 LSBs
  localparam logic [15:0] LIN_STEP [16] = '{
    16'h6531, 16'h5061, 16'h3fd9, 16'h32b7,
    16'h2849, 16'h2000, 16'h196b, 16'h1431,
    16'h100a, 16'h0cbd, 16'h0a1f, 16'h080a,
    16'h0663, 16'h0512, 16'h0407, 16'h0333
  };

  typedef struct packed {
    logic [LOC_AW-1:0] addr;
    logic [TGT_W-1:0] data;
  } tgt_wr_s;
endpackage

// [ramp_monitor.sv]
// Purpose: Sweep timing checks for the ramp engine
// Assumes: One 64-location sweep per accepted frame tick
// Notes: Bound to every engine instance
`timescale 1ns/100ps
module ramp_monitor (
  input wire logic i_clk_sys, // Clock
  input wire logic i_arst_n, // Reset
  input wire logic i_frame_tick, // Frame pulse
  input wire logic [5:0] i_rd_addr, // Read address
  input wire logic [27:0] o_rd_slew, // Read data
  input wire logic o_sweep_busy, // Sweep running
  input wire logic o_frame_done // Sweep end
);
  logic [6:0] cnt_ff;
  // Busy length, cleared between sweeps so every sweep is judged alone
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) cnt_ff <= 7'h00;
    else cnt_ff <= o_sweep_busy ? cnt_ff + 7'h01 : 7'h00;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_end;
    !o_sweep_busy && o_frame_done ##1 !o_frame_done;
  endsequence
  property p_start; i_frame_tick && !o_sweep_busy |=> o_sweep_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("sweep did not start");
  property p_idle; !i_frame_tick && !o_sweep_busy |=> !o_sweep_busy;
  endproperty
  a_idle: assert property (p_idle)
    else $error("sweep started without tick");
  property p_span; $rose(o_sweep_busy) |-> ##64 s_end; endproperty
  a_span: assert property (p_span)
    else $error("sweep end not after 64 cycles");
  property p_cnt; o_sweep_busy |-> cnt_ff < 7'h40; endproperty
  a_cnt: assert property (p_cnt)
    else $error("sweep too long");
  property p_len; o_frame_done |-> cnt_ff == 7'h40; endproperty
  a_len: assert property (p_len)
    else $error("done without a full sweep");
  property p_src; o_frame_done |-> $past(o_sweep_busy); endproperty
  a_src: assert property (p_src)
    else $error("done without preceding sweep");
  property p_fall; $fell(o_sweep_busy) |-> o_frame_done; endproperty
  a_fall: assert property (p_fall)
    else $error("sweep ended without done");
  // Slew only moves inside a sweep, so a steady address reads steady data
  property p_hold; $past(i_arst_n) && !o_sweep_busy && !o_frame_done
    && $stable(i_rd_addr) |=> $stable(o_rd_slew); endproperty
  a_hold: assert property (p_hold)
    else $error("slew moved outside a sweep");
endmodule
bind target_slew_ramp_engine ramp_monitor u_mon (.i_clk_sys, .i_arst_n,
  .i_frame_tick, .i_rd_addr, .o_rd_slew, .o_sweep_busy, .o_frame_done);

// [ramp_host.sv]
// Purpose: Host model writing target words
// Assumes: One-cycle strobe launched after the falling edge
// Notes: Idle data lines toggle so a stale word is never trusted
`timescale 1ns/100ps
module ramp_host (
  input wire logic i_clk_sys, // Clock
  output logic o_tgt_wr, // Write strobe
  output ramp_pkg::tgt_wr_s o_tgt_wr_req // Address and word
);
  import ramp_pkg::*;
  initial begin
    o_tgt_wr = 1'b0;
    o_tgt_wr_req = '0;
  end
  // Constant-time word: refresh flag, step code, data, reserved zero
  function automatic logic [33:0] ct_word(input logic r, input logic [2:0] c,
    input logic [15:0] d);
    return {2'h3, r, c, d, 12'h000};
  endfunction
  // Whole 34-bit word, driven unpadded in a single strobe
  task automatic put(input logic [5:0] a, input logic [33:0] w);
    @(negedge i_clk_sys);
    o_tgt_wr = 1'b1;
    o_tgt_wr_req = '{addr: a, data: w};
    @(negedge i_clk_sys);
    o_tgt_wr = 1'b0;
    o_tgt_wr_req.data = ~w;
  endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the ramp engine
// Assumes: 40 MHz clock, frame ticks 70 clocks apart
// Notes: Seeded random picks a location and time constant
`timescale 1ns/100ps
module tb_top;
  import ramp_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_frame_tick = 1'b0;
  logic i_mute = 1'b0;
  logic [5:0] i_rd_addr = 6'h00;
  logic i_tgt_wr;
  tgt_wr_s i_tgt_wr_req;
  logic [27:0] o_rd_slew;
  logic o_sweep_busy;
  logic o_frame_done;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [5:0] loc;
  logic [3:0] tc;
  always #12.5 i_clk_sys = ~i_clk_sys;
  ramp_host host (.i_clk_sys, .o_tgt_wr(i_tgt_wr),
    .o_tgt_wr_req(i_tgt_wr_req));
  target_slew_ramp_engine DUT (.i_clk_sys, .i_arst_n, .i_tgt_wr,
    .i_tgt_wr_req, .i_frame_tick, .i_mute, .i_rd_addr, .o_rd_slew,
    .o_sweep_busy, .o_frame_done);
  task automatic check(input string n, input logic [27:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well above the ~5000 cycles the run needs
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      summarize();
    end
  end
  // Tick, then wait out the sweep while reads wander at random
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge i_clk_sys) i_frame_tick = 1'b1;
      @(negedge i_clk_sys) i_frame_tick = 1'b0;
      check("busy", {27'h0, o_sweep_busy}, 28'h1);
      // Busy spans 64 cycles, then done pulses once as busy falls
      for (int k = 1; k <= 68; k++) begin
        @(negedge i_clk_sys) i_rd_addr = 6'($urandom);
        if (k == 63) begin
          check("run", {26'h0, o_sweep_busy, o_frame_done}, 28'h2);
        end
        if (k == 64) begin
          check("end", {26'h0, o_sweep_busy, o_frame_done}, 28'h1);
        end
      end
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [27:0] e);
    @(negedge i_clk_sys) i_rd_addr = a;
    @(negedge i_clk_sys);
    check("slew", o_rd_slew, e);
  endtask
  function automatic logic [27:0] lin_down(input logic [3:0] t, input int n);
    return VAL_ONE - 28'(n) * {12'h000, LIN_STEP[t]};
  endfunction
  initial begin
    void'($urandom(32'h6e97));
    repeat (16) @(negedge i_clk_sys);
    check("reset", o_rd_slew, 28'h0);
    i_arst_n = 1'b1;
    loc = {1'b0, 5'($urandom)};
    tc = 4'($urandom);
    rd(loc, VAL_ONE);
    host.put(loc, {2'h0, tc, 28'h0});
    frames(2);
    rd(loc, lin_down(tc, 2));
    // Each curve code once; the clamp target sits half a step away
    host.put(6'h20, {2'h0, 4'h5, 28'h07ff000});
    host.put(6'h21, {2'h1, 4'h0, 28'h0});
    host.put(6'h22, {2'h2, 4'h0, 28'h0400000});
    host.put(6'h23, host.ct_word(1'b1, 3'h0, 16'h0000));
    // A longer step code halves the step, so it is only half way at the end
    host.put(6'h25, host.ct_word(1'b1, 3'h1, 16'h0000));
    frames(1);
    rd(6'h20, 28'h07ff000);
    rd(6'h21, 28'h0780000);
    rd(6'h22, 28'h07c0000);
    rd(6'h23, VAL_ONE);
    i_mute = 1'b1;
    frames(3);
    rd(6'h24, lin_down(4'h5, 3));
    rd(6'h23, VAL_ONE - 28'h0060000);
    i_mute = 1'b0;
    frames(1);
    rd(6'h24, lin_down(4'h5, 2));
    frames(59);
    rd(6'h23, 28'h0020000);
    frames(1);
    rd(6'h23, 28'h0);
    rd(6'h25, 28'h0400000);
    // Reset in mid-sweep brings the defaults back
    @(negedge i_clk_sys) i_frame_tick = 1'b1;
    @(negedge i_clk_sys) i_frame_tick = 1'b0;
    @(negedge i_clk_sys) i_arst_n = 1'b0;
    @(negedge i_clk_sys) i_arst_n = 1'b1;
    check("busy", {27'h0, o_sweep_busy}, 28'h0);
    rd(6'h23, VAL_ONE);
    summarize();
  end
endmodule
